// >>> pmw_pkg.sv
/*
  pmw_pkg: constants and helper functions for the message-window target
  image (register offsets, field positions, reset values, decode helpers).
  assumes: every design file of the block refers to it as pmw_pkg::name.
*/
package pmw_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [11:0] CTL_OFFSET = 12'h500;
  localparam logic [11:0] XLATE_OFFSET = 12'h504;
  localparam logic [11:0] BASE_OFFSET = 12'h510;
  // control register field positions
  localparam int WIN_EN_BIT = 31;
  localparam int XLATE_EN_BIT = 30;
  localparam int BAR_EN_BIT = 29;
  localparam int BS_LSB = 24;
  localparam int RTT_LSB = 16;
  localparam int GBL_BIT = 15;
  localparam int CI_BIT = 14;
  localparam int WTT_LSB = 8;
  localparam int KEEP_BIT = 7;
  localparam int END_LSB = 5;
  localparam int MRA_BIT = 4;
  localparam int AMT_LSB = 0;
  // upper half of the translation and base registers holds the field
  localparam int UPPER_LSB = 16;
  // reset values of the control fields
  localparam logic [4:0] RTT_RESET = 5'h0A;
  localparam logic [4:0] WTT_RESET = 5'h02;
  localparam logic [1:0] END_RESET = 2'h2;
  localparam logic [3:0] BS_RESET = 4'h0;
  localparam logic [2:0] AMT_RESET = 3'h0;
  // shell part of the window is the lowest 4 KB: offset bits 31:12 zero
  localparam int SHELL_LSB = 12;
  // shell reads, and plain reads unless aliased, prefetch a fixed 8 bytes
  localparam logic [7:0] BASE_PREFETCH = 8'h08;
  // largest legal prefetch code (128 bytes)
  localparam logic [2:0] AMT_MAX = 3'h4;

  // compared/translated upper address lines AD31..AD(16+bs)
  function automatic logic [15:0] upper_mask(input logic [3:0] bs);
    upper_mask = 16'hFFFF << bs;
  endfunction

  // prefetch bytes for a code; reserved codes fall back to 8 bytes
  function automatic logic [7:0] prefetch_bytes(input logic [2:0] code);
    prefetch_bytes = (code > AMT_MAX) ? BASE_PREFETCH : (BASE_PREFETCH << code);
  endfunction
endpackage

// >>> pmw_cfg_if.sv
/*
  pmw_cfg_if: carries window configuration and the request under decode
  from the control module to the decode and attribute modules.
  assumes: one driver per signal, the control module owns configuration.
*/
`timescale 1ns/1ps
interface pmw_cfg_if;
  // configuration from the control registers
  logic windowEnable;
  logic translateEnable;
  logic [3:0] blockSizeCode;
  logic [15:0] baseAddr;
  logic [15:0] translationField;
  logic [4:0] readTxnType;
  logic [4:0] writeTxnType;
  logic readKeepEnable;
  logic [1:0] endianMode;
  logic readAliasMultiple;
  logic [2:0] prefetchAmount;
  // request under decode
  logic [31:0] reqAddr;
  logic reqWrite;
  logic reqReadMultiple;
  // decode results
  logic hit;
  logic shell;
  logic [31:0] xlatedAddr;
  logic [4:0] txnType;
  logic [7:0] prefetchBytes;
  logic readKeep;
  logic [1:0] endianOut;

  modport ctl (output windowEnable, translateEnable, blockSizeCode, baseAddr,
    translationField, readTxnType, writeTxnType, readKeepEnable, endianMode,
    readAliasMultiple, prefetchAmount, reqAddr, reqWrite, reqReadMultiple,
    input hit, shell, xlatedAddr, txnType, prefetchBytes, readKeep, endianOut);
  modport xlate (input windowEnable, translateEnable, blockSizeCode, baseAddr,
    translationField, reqAddr, output hit, shell, xlatedAddr);
  modport attr (input readTxnType, writeTxnType, readKeepEnable, endianMode,
    readAliasMultiple, prefetchAmount, reqWrite, reqReadMultiple, shell,
    output txnType, prefetchBytes, readKeep, endianOut);
endinterface

// >>> pmw_addr_xlate.sv
/*
  pmw_addr_xlate: window hit compare, shell detect and address translation.
  assumes: configuration and request address arrive on the xlate modport.
*/
`timescale 1ns/1ps
module pmw_addr_xlate
(
  // configuration and request
  pmw_cfg_if.xlate cfg
);
  // upper lines compared and translated for this block size
  wire [15:0] upperMask = pmw_pkg::upper_mask(cfg.blockSizeCode);
  wire [31:0] fullMask = {upperMask, 16'h0000};
  // offset of the access inside the window
  wire [31:0] winOffset = cfg.reqAddr & ~fullMask;
  // upper-line compare against the programmed base
  wire baseMatch = ((cfg.reqAddr[31:16] ^ cfg.baseAddr) & upperMask) == 16'h0000;
  // translated address: upper lines replaced by the translation field
  wire [31:0] substAddr = winOffset | ({cfg.translationField, 16'h0000} & fullMask);

  // claim only an enabled window with a matching base
  assign cfg.hit = cfg.windowEnable & baseMatch;
  // lowest 4 KB reaches the shell, the rest the message frames
  assign cfg.shell = winOffset[31:pmw_pkg::SHELL_LSB] == 20'h00000;
  // shell accesses never translate
  assign cfg.xlatedAddr = (cfg.translateEnable & ~cfg.shell) ? substAddr
    : cfg.reqAddr;
endmodule

// >>> pmw_attr_gen.sv
/*
  pmw_attr_gen: processor bus transaction type, prefetch size, read keep and
  byte order for the request under decode.
  assumes: shell flag comes from the address decode on the same interface.
*/
`timescale 1ns/1ps
module pmw_attr_gen
(
  // configuration and request
  pmw_cfg_if.attr cfg
);
  // plain reads prefetch the programmed amount only when aliased
  wire useAmount = ~cfg.shell & (cfg.reqReadMultiple | cfg.readAliasMultiple);
  // read or write transaction type
  assign cfg.txnType = cfg.reqWrite ? cfg.writeTxnType : cfg.readTxnType;
  // writes fetch nothing; shell reads fixed at 8 bytes
  assign cfg.prefetchBytes = cfg.reqWrite ? 8'h00
    : (useAmount ? pmw_pkg::prefetch_bytes(cfg.prefetchAmount)
    : pmw_pkg::BASE_PREFETCH);
  // read keep off for shell accesses
  assign cfg.readKeep = cfg.readKeepEnable & ~cfg.shell & ~cfg.reqWrite;
  // shell accesses use the reset byte order, no conversion selection
  assign cfg.endianOut = cfg.shell ? pmw_pkg::END_RESET : cfg.endianMode;
endmodule

// >>> pmw_target_image.sv
/*
  pmw_target_image: control of the message-window target image: control,
  translation and window base registers on a classic wishbone slave, and
  forwarding of claimed accesses to the processor bus.
  assumes: PCI request side and processor bus run on sys_clk; rst_b is the
  primary reset; config memory loads arrive as same-clock pulses.
// Operation
// - low 4 KB reaches the shell interface
// - above 4 KB reaches message frames
// - claimed accesses go only to processor bus
// - shell ignores translation, keep and byte order
// - shell reads prefetch exactly 8 bytes
// - enable sets on first base write
// - enable clears on zero writes; gates access
// - translation field replaces upper address lines
// - base register visible only when enabled
// - hidden base register ignores writes
// - window size is 64 KB shifted
// - read type drives lines, resets 01010
// - write type drives lines, resets 00010
// - global and inhibit bits drive attributes
// - code zero compares AD31 to AD16
// - prefetch code selects 8 to 128
// - byte order field resets to big
*/
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module pmw_target_image
(
  // clock and primary reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone register slave
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [11:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  // configuration memory load of straps
  input wire logic cfgLoad,
  input wire logic cfgBarEnable,
  input wire logic [3:0] cfgBlockSize,
  // PCI memory request from the target state machine
  input wire logic pciReqValid,
  input wire logic [31:0] pciAddr,
  input wire logic pciWrite,
  input wire logic pciReadMultiple,
  output logic pciClaim,
  output logic pciAccept,
  // processor bus request
  output logic pbusValid,
  input wire logic pbusReady,
  output logic [31:0] pbusAddr,
  output logic pbusWrite,
  output logic pbusShell,
  output logic [4:0] pbusTxnTypeLines,
  output logic pbusGlobalN,
  output logic pbusCacheInhibitN,
  output logic [7:0] pbusPrefetchBytes,
  output logic pbusReadKeep,
  output logic [1:0] pbusEndianMode
);
  // shared configuration and decode carrier
  pmw_cfg_if cfg ();

  // control register fields
  logic windowEnable_reg, windowEnable_next;
  logic translateEnable_reg, translateEnable_next;
  logic barEnable_reg, barEnable_next;
  logic [3:0] blockSize_reg, blockSize_next;
  logic [4:0] readTxn_reg, readTxn_next;
  logic [4:0] writeTxn_reg, writeTxn_next;
  logic globalSel_reg, globalSel_next;
  logic cacheInhSel_reg, cacheInhSel_next;
  logic readKeepEn_reg, readKeepEn_next;
  logic [1:0] endian_reg, endian_next;
  logic readAlias_reg, readAlias_next;
  logic [2:0] prefetchAmt_reg, prefetchAmt_next;
  // translation field and window base field
  logic [15:0] translation_reg, translation_next;
  logic [15:0] base_reg, base_next;
  // base field written at least once since reset
  logic baseWritten_reg, baseWritten_next;
  // wishbone answer
  logic wbAck_reg;
  logic [31:0] wbDat_reg, wbDat_next;
  // processor bus request holding registers
  logic pbValid_reg;
  logic [31:0] pbAddr_reg;
  logic pbWrite_reg, pbShell_reg, pbKeep_reg, pbGblN_reg, pbCiN_reg;
  logic [4:0] pbTxn_reg;
  logic [7:0] pbPref_reg;
  logic [1:0] pbEnd_reg;

  // byte-lane mask from the select lines
  wire [31:0] laneMask = {{8{wbSelI[3]}}, {8{wbSelI[2]}}, {8{wbSelI[1]}},
    {8{wbSelI[0]}}};
  // new wishbone request, taken once per cycle of the bus
  wire wbReq = wbCycI & wbStbI & ~wbAck_reg;
  wire wbWrite = wbReq & wbWeI;
  // address decode
  wire selCtl = wbAdrI == pmw_pkg::CTL_OFFSET;
  wire selXlate = wbAdrI == pmw_pkg::XLATE_OFFSET;
  wire selBase = wbAdrI == pmw_pkg::BASE_OFFSET;

  // control register image as read back
  wire [31:0] ctlImage = ({31'h0, windowEnable_reg} << pmw_pkg::WIN_EN_BIT)
    | ({31'h0, translateEnable_reg} << pmw_pkg::XLATE_EN_BIT)
    | ({31'h0, barEnable_reg} << pmw_pkg::BAR_EN_BIT)
    | ({28'h0, blockSize_reg} << pmw_pkg::BS_LSB)
    | ({27'h0, readTxn_reg} << pmw_pkg::RTT_LSB)
    | ({31'h0, globalSel_reg} << pmw_pkg::GBL_BIT)
    | ({31'h0, cacheInhSel_reg} << pmw_pkg::CI_BIT)
    | ({27'h0, writeTxn_reg} << pmw_pkg::WTT_LSB)
    | ({31'h0, readKeepEn_reg} << pmw_pkg::KEEP_BIT)
    | ({30'h0, endian_reg} << pmw_pkg::END_LSB)
    | ({31'h0, readAlias_reg} << pmw_pkg::MRA_BIT)
    | ({29'h0, prefetchAmt_reg} << pmw_pkg::AMT_LSB);
  // implemented bits below the block size read as zero
  wire [15:0] baseVisible = base_reg & pmw_pkg::upper_mask(blockSize_reg);
  // hidden base register reads zero
  wire [31:0] baseImage = barEnable_reg ? {baseVisible, 16'h0000}
    : 32'h0000_0000;
  wire [31:0] xlateImage = {translation_reg, 16'h0000};

  // merged write data for each register
  wire [31:0] ctlMerged = (ctlImage & ~laneMask) | (wbDatI & laneMask);
  wire [31:0] xlateMerged = (xlateImage & ~laneMask) | (wbDatI & laneMask);
  wire [31:0] baseMerged = ({base_reg, 16'h0000} & ~laneMask) | (wbDatI & laneMask);
  // base field write: needs the register visible and an upper lane
  wire baseFieldWr = wbWrite & selBase & barEnable_reg
    & (wbSelI[3] | wbSelI[2]);
  wire [15:0] baseNewVal = baseMerged[31:16] & pmw_pkg::upper_mask(blockSize_reg);
  wire baseZeroWr = baseFieldWr & (baseNewVal == 16'h0000);
  wire baseFirstWr = baseFieldWr & ~baseWritten_reg;
  wire ctlWr = wbWrite & selCtl;

  // read multiplexer; unmapped addresses read zero
  assign wbDat_next = ~wbReq ? wbDat_reg
    : selCtl ? ctlImage
    : selXlate ? xlateImage
    : selBase ? baseImage
    : 32'h0000_0000;

  // window enable: register write, first base write, zero base write
  always_comb
  begin
    windowEnable_next = windowEnable_reg;
    // direct write to the enable bit sets or clears it
    if (ctlWr & wbSelI[3])
    begin
      windowEnable_next = ctlMerged[pmw_pkg::WIN_EN_BIT];
    end
    // zero base clears, first nonzero base sets
    if (baseZeroWr)
    begin
      windowEnable_next = 1'b0;
    end
    else if (baseFirstWr)
    begin
      windowEnable_next = 1'b1;
    end
  end

  // remaining control fields from control register writes; config loads win for bar enable and block size
  assign translateEnable_next = (ctlWr & wbSelI[3])
    ? ctlMerged[pmw_pkg::XLATE_EN_BIT] : translateEnable_reg;
  assign barEnable_next = cfgLoad ? cfgBarEnable
    : (ctlWr & wbSelI[3]) ? ctlMerged[pmw_pkg::BAR_EN_BIT]
    : barEnable_reg;
  assign blockSize_next = cfgLoad ? cfgBlockSize
    : (ctlWr & wbSelI[3]) ? ctlMerged[pmw_pkg::BS_LSB +: 4]
    : blockSize_reg;
  assign readTxn_next = (ctlWr & wbSelI[2])
    ? ctlMerged[pmw_pkg::RTT_LSB +: 5] : readTxn_reg;
  assign globalSel_next = (ctlWr & wbSelI[1])
    ? ctlMerged[pmw_pkg::GBL_BIT] : globalSel_reg;
  assign cacheInhSel_next = (ctlWr & wbSelI[1])
    ? ctlMerged[pmw_pkg::CI_BIT] : cacheInhSel_reg;
  assign writeTxn_next = (ctlWr & wbSelI[1])
    ? ctlMerged[pmw_pkg::WTT_LSB +: 5] : writeTxn_reg;
  assign readKeepEn_next = (ctlWr & wbSelI[0])
    ? ctlMerged[pmw_pkg::KEEP_BIT] : readKeepEn_reg;
  assign endian_next = (ctlWr & wbSelI[0])
    ? ctlMerged[pmw_pkg::END_LSB +: 2] : endian_reg;
  assign readAlias_next = (ctlWr & wbSelI[0])
    ? ctlMerged[pmw_pkg::MRA_BIT] : readAlias_reg;
  assign prefetchAmt_next = (ctlWr & wbSelI[0])
    ? ctlMerged[pmw_pkg::AMT_LSB +: 3] : prefetchAmt_reg;
  // translation and base fields
  assign translation_next = (wbWrite & selXlate)
    ? xlateMerged[31:16] : translation_reg;
  assign base_next = baseFieldWr ? baseNewVal : base_reg;
  assign baseWritten_next = baseWritten_reg | baseFieldWr;

  // control fields: primary reset restores documented values
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      windowEnable_reg <= 1'b0;
      translateEnable_reg <= 1'b0;
      barEnable_reg <= 1'b0;
      blockSize_reg <= pmw_pkg::BS_RESET;
      readTxn_reg <= pmw_pkg::RTT_RESET;
      writeTxn_reg <= pmw_pkg::WTT_RESET;
      globalSel_reg <= 1'b0;
      cacheInhSel_reg <= 1'b0;
      readKeepEn_reg <= 1'b0;
      endian_reg <= pmw_pkg::END_RESET;
      readAlias_reg <= 1'b0;
      prefetchAmt_reg <= pmw_pkg::AMT_RESET;
    end
    else
    begin
      windowEnable_reg <= windowEnable_next;
      translateEnable_reg <= translateEnable_next;
      barEnable_reg <= barEnable_next;
      blockSize_reg <= blockSize_next;
      readTxn_reg <= readTxn_next;
      writeTxn_reg <= writeTxn_next;
      globalSel_reg <= globalSel_next;
      cacheInhSel_reg <= cacheInhSel_next;
      readKeepEn_reg <= readKeepEn_next;
      endian_reg <= endian_next;
      readAlias_reg <= readAlias_next;
      prefetchAmt_reg <= prefetchAmt_next;
    end
  end

  // translation, base and first-write flag
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      translation_reg <= 16'h0000;
      base_reg <= 16'h0000;
      baseWritten_reg <= 1'b0;
    end
    else
    begin
      translation_reg <= translation_next;
      base_reg <= base_next;
      baseWritten_reg <= baseWritten_next;
    end
  end

  // wishbone answer: ack one cycle after the request, for one cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wbAck_reg <= 1'b0;
      wbDat_reg <= 32'h0000_0000;
    end
    else
    begin
      wbAck_reg <= wbReq;
      wbDat_reg <= wbDat_next;
    end
  end
  assign wbAckO = wbAck_reg;
  assign wbDatO = wbDat_reg;

  // configuration onto the carrier
  assign cfg.windowEnable = windowEnable_reg;
  assign cfg.translateEnable = translateEnable_reg;
  assign cfg.blockSizeCode = blockSize_reg;
  assign cfg.baseAddr = baseVisible;
  assign cfg.translationField = translation_reg;
  assign cfg.readTxnType = readTxn_reg;
  assign cfg.writeTxnType = writeTxn_reg;
  assign cfg.readKeepEnable = readKeepEn_reg;
  assign cfg.endianMode = endian_reg;
  assign cfg.readAliasMultiple = readAlias_reg;
  assign cfg.prefetchAmount = prefetchAmt_reg;
  assign cfg.reqAddr = pciAddr;
  assign cfg.reqWrite = pciWrite;
  assign cfg.reqReadMultiple = pciReadMultiple;

  // window compare and translation
  pmw_addr_xlate addrXlate (
    .cfg(cfg)
  );
  // transaction attributes
  pmw_attr_gen attrGen (
    .cfg(cfg)
  );

  // claim and accept: one request held toward the processor bus
  assign pciClaim = pciReqValid & cfg.hit;
  assign pciAccept = pciClaim & (~pbValid_reg | pbusReady);
  wire pbDone = pbValid_reg & pbusReady;

  // processor bus request registers; every accepted claim goes there
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pbValid_reg <= 1'b0;
      pbAddr_reg <= 32'h0000_0000;
      pbWrite_reg <= 1'b0;
      pbShell_reg <= 1'b0;
      pbTxn_reg <= 5'h00;
      pbGblN_reg <= 1'b1;
      pbCiN_reg <= 1'b1;
      pbPref_reg <= 8'h00;
      pbKeep_reg <= 1'b0;
      pbEnd_reg <= pmw_pkg::END_RESET;
    end
    else if (pciAccept)
    begin
      pbValid_reg <= 1'b1;
      pbAddr_reg <= cfg.xlatedAddr;
      pbWrite_reg <= pciWrite;
      pbShell_reg <= cfg.shell;
      pbTxn_reg <= cfg.txnType;
      pbGblN_reg <= globalSel_reg;
      pbCiN_reg <= cacheInhSel_reg;
      pbPref_reg <= cfg.prefetchBytes;
      pbKeep_reg <= cfg.readKeep;
      pbEnd_reg <= cfg.endianOut;
    end
    else if (pbDone)
    begin
      pbValid_reg <= 1'b0;
    end
  end

  // processor bus outputs
  assign pbusValid = pbValid_reg;
  assign pbusAddr = pbAddr_reg;
  assign pbusWrite = pbWrite_reg;
  assign pbusShell = pbShell_reg;
  assign pbusTxnTypeLines = pbTxn_reg;
  assign pbusGlobalN = pbGblN_reg;
  assign pbusCacheInhibitN = pbCiN_reg;
  assign pbusPrefetchBytes = pbPref_reg;
  assign pbusReadKeep = pbKeep_reg;
  assign pbusEndianMode = pbEnd_reg;
endmodule

// >>> pmw_target_image_properties.sv
/*
  pmw_target_image_properties: port-level checks of the target image.
  assumes: bound to every pmw_target_image, one clock domain on sys_clk.
*/
`timescale 1ns/1ps
module pmw_target_image_properties
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register bus
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbAckO,
  // request path
  input wire logic pciReqValid,
  input wire logic pciClaim,
  input wire logic pciAccept,
  input wire logic pbusValid,
  input wire logic pbusReady,
  input wire logic pbusWrite,
  input wire logic pbusShell,
  input wire logic [31:0] pbusAddr,
  input wire logic [4:0] pbusTxnTypeLines,
  input wire logic [7:0] pbusPrefetchBytes,
  input wire logic pbusReadKeep,
  input wire logic [1:0] pbusEndianMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // one ack per taken request, one cycle wide
  property p_wb_ack; wbCycI && wbStbI && !wbAckO |=> wbAckO ##1 !wbAckO; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after request");
  property p_claim; pciClaim |-> pciReqValid; endproperty
  a_claim: assert property (p_claim) else $error("claim without request");
  property p_accept; pciAccept |-> pciClaim; endproperty
  a_accept: assert property (p_accept) else $error("accept without claim");
  property p_fwd; pciAccept |=> pbusValid; endproperty
  a_fwd: assert property (p_fwd) else $error("accepted access not forwarded");
  // held request blocks new ones and stands still
  property p_hold;
    pbusValid && !pbusReady |-> !pciAccept ##1 (pbusValid && $stable(pbusAddr)
      && $stable(pbusTxnTypeLines) && $stable(pbusWrite));
  endproperty
  a_hold: assert property (p_hold) else $error("held request changed");
  property p_drop; pbusValid && pbusReady && !pciAccept |=> !pbusValid; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ready");
  property p_shell;
    pbusValid && pbusShell |-> !pbusReadKeep && pbusEndianMode == 2'h2
      && pbusAddr[15:12] == 4'h0;
  endproperty
  a_shell: assert property (p_shell) else $error("shell access attributes wrong");
  property p_shell_pf; pbusValid && pbusShell && !pbusWrite |-> pbusPrefetchBytes == 8'h08;
  endproperty
  a_shell_pf: assert property (p_shell_pf) else $error("shell prefetch not 8");
  property p_pf_set;
    pbusValid |-> (pbusWrite ? pbusPrefetchBytes == 8'h00
      : pbusPrefetchBytes inside {8'h08, 8'h10, 8'h20, 8'h40, 8'h80});
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("prefetch size illegal");
  // main scenarios
  c_shell: cover property (pbusValid && pbusShell && !pbusWrite);
  c_big: cover property (pbusValid && pbusPrefetchBytes == 8'h80);
  c_stall: cover property (pbusValid && !pbusReady && pciReqValid);
endmodule
bind pmw_target_image pmw_target_image_properties i_pmw_target_image_properties (
  .sys_clk(sys_clk), .rst_b(rst_b), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbAckO(wbAckO),
  .pciReqValid(pciReqValid), .pciClaim(pciClaim), .pciAccept(pciAccept),
  .pbusValid(pbusValid), .pbusReady(pbusReady), .pbusWrite(pbusWrite),
  .pbusShell(pbusShell), .pbusAddr(pbusAddr), .pbusTxnTypeLines(pbusTxnTypeLines),
  .pbusPrefetchBytes(pbusPrefetchBytes), .pbusReadKeep(pbusReadKeep),
  .pbusEndianMode(pbusEndianMode));

// >>> pmw_pbus_model.sv
/*
  pmw_pbus_model: processor bus side, answers held requests with ready.
  assumes: same clock as the target image; slowMode stretches stalls.
*/
`timescale 1ns/1ps
module pmw_pbus_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // handshake
  input wire logic pbusValid,
  input wire logic slowMode,
  output logic pbusReady
);
  logic [7:0] lfsrReg; // stall pattern source
  wire readyNext = slowMode ? (lfsrReg[2:0] == 3'h0) : lfsrReg[0];
  // ready pattern, changes right after each edge
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      lfsrReg <= 8'h5A;
      pbusReady <= 1'b0;
    end
    else
    begin
      lfsrReg <= {lfsrReg[6:0], lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
      pbusReady <= readyNext && pbusValid;
    end
endmodule

// >>> tb.sv
/*
  tb: self-checking bench of the target image against a bench model.
  assumes: design and pmw_pbus_model compiled first; 100 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  logic sys_clk, rst_b, wbCycI, wbStbI, wbWeI, wbAckO, cfgLoad, cfgBarEnable, slowMode;
  logic [11:0] wbAdrI;
  logic [3:0] wbSelI, cfgBlockSize;
  logic [31:0] wbDatI, wbDatO, pciAddr, pbusAddr, seed, rdat, r, a, ctlV;
  logic pciReqValid, pciWrite, pciReadMultiple, pciClaim, pciAccept, pbusValid, pbusReady;
  logic pbusWrite, pbusShell, pbusGlobalN, pbusCacheInhibitN, pbusReadKeep, winEn;
  logic [4:0] pbusTxnTypeLines;
  logic [7:0] pbusPrefetchBytes;
  logic [1:0] pbusEndianMode;
  logic [15:0] tfV, baseV, mk;
  int error_cnt, cmp_count;
  pmw_target_image i_pmw_target_image (.sys_clk(sys_clk), .rst_b(rst_b), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .cfgLoad(cfgLoad), .cfgBarEnable(cfgBarEnable),
    .cfgBlockSize(cfgBlockSize), .pciReqValid(pciReqValid), .pciAddr(pciAddr),
    .pciWrite(pciWrite), .pciReadMultiple(pciReadMultiple), .pciClaim(pciClaim),
    .pciAccept(pciAccept), .pbusValid(pbusValid), .pbusReady(pbusReady),
    .pbusAddr(pbusAddr), .pbusWrite(pbusWrite), .pbusShell(pbusShell),
    .pbusTxnTypeLines(pbusTxnTypeLines), .pbusGlobalN(pbusGlobalN),
    .pbusCacheInhibitN(pbusCacheInhibitN), .pbusPrefetchBytes(pbusPrefetchBytes),
    .pbusReadKeep(pbusReadKeep), .pbusEndianMode(pbusEndianMode));
  pmw_pbus_model i_pmw_pbus_model (.sys_clk(sys_clk), .rst_b(rst_b), .pbusValid(pbusValid),
    .slowMode(slowMode), .pbusReady(pbusReady));
  // xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // verdict and end of run
  task finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // classic wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wbCycI <= 1'b1; wbStbI <= 1'b1; wbWeI <= we; wbAdrI <= ad; wbDatI <= d;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (wbAckO !== 1'b1 && n < 50);
    // a missing ack counts as a mismatch
    if (wbAckO !== 1'b1) error_cnt++;
    rdat = wbDatO;
    wbCycI <= 1'b0; wbStbI <= 1'b0;
  endtask
  task rd(input logic [11:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 32'h0);
    `CHK(rdat, e)
  endtask
  // one PCI request, expectations from the bench model
  task req(input logic [31:0] ad, input logic w, input logic m);
    logic hit, sh;
    logic [31:0] xa;
    logic [7:0] pf;
    int n;
    mk = 16'hFFFF << ctlV[27:24];
    hit = winEn && (((ad[31:16] ^ baseV) & mk) == 16'h0);
    sh = ((ad[31:16] & ~mk) == 16'h0) && (ad[15:12] == 4'h0);
    xa = (ctlV[30] && !sh) ? {(tfV & mk) | (ad[31:16] & ~mk), ad[15:0]} : ad;
    pf = (sh || (!m && !ctlV[4]) || ctlV[2:0] > 3'h4) ? 8'h08 : 8'h08 << ctlV[2:0];
    if (w) pf = 8'h00;
    @(posedge sys_clk);
    pciReqValid <= 1'b1; pciAddr <= ad; pciWrite <= w; pciReadMultiple <= m;
    @(negedge sys_clk);
    `CHK(pciClaim, hit)
    n = 0;
    while (hit && pciAccept !== 1'b1 && n < 100) begin @(negedge sys_clk); n++; end
    // a claim that is never accepted counts as a mismatch
    if (hit && pciAccept !== 1'b1) error_cnt++;
    @(posedge sys_clk);
    pciReqValid <= 1'b0;
    if (hit)
    begin
      #1;
      `CHK(pbusValid, 1'b1)
      `CHK(pbusAddr, xa)
      `CHK({pbusShell, pbusWrite}, {sh, w})
      `CHK(pbusTxnTypeLines, w ? ctlV[12:8] : ctlV[20:16])
      `CHK({pbusGlobalN, pbusCacheInhibitN}, ctlV[15:14])
      `CHK(pbusPrefetchBytes, pf)
      `CHK({pbusReadKeep, pbusEndianMode}, {ctlV[7] && !w && !sh, sh ? 2'h2 : ctlV[6:5]})
    end
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog
  initial
  begin
    #300000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    rst_b = 1'b0; wbCycI = 1'b0; wbStbI = 1'b0; wbWeI = 1'b0; wbAdrI = 12'h0;
    wbSelI = 4'hF; wbDatI = 32'h0; cfgLoad = 1'b0; cfgBarEnable = 1'b0; cfgBlockSize = 4'h0;
    pciReqValid = 1'b0; pciAddr = 32'h0; pciWrite = 1'b0; pciReadMultiple = 1'b0;
    slowMode = 1'b0; seed = 32'h00000044; error_cnt = 0; cmp_count = 0;
    ctlV = 32'h000A0240; tfV = 16'h0; baseV = 16'h0; winEn = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(12'h500, 32'h000A0240);
    rd(12'h7FC, 32'h0);
    wb(1'b1, 12'h510, 32'h12340000);
    rd(12'h510, 32'h0);
    req(32'h12340100, 1'b0, 1'b0);
    @(posedge sys_clk);
    cfgLoad <= 1'b1; cfgBarEnable <= 1'b1; cfgBlockSize <= 4'h1;
    @(posedge sys_clk);
    cfgLoad <= 1'b0;
    ctlV = 32'h210A0240;
    rd(12'h500, ctlV);
    wb(1'b1, 12'h510, 32'h12350000);
    baseV = 16'h1234; winEn = 1'b1; ctlV[31] = 1'b1;
    rd(12'h510, 32'h12340000);
    // base write on the lower lanes only must leave the field alone
    wbSelI <= 4'h3;
    wb(1'b1, 12'h510, 32'h56780000);
    wbSelI <= 4'hF;
    rd(12'h510, 32'h12340000);
    rd(12'h500, ctlV);
    for (int i = 0; i < 64; i++)
    begin
      slowMode <= i[3];
      ctlV = (xs() & 32'h401FDFF0) | 32'hA0000000 | (32'(i % 16) << 24) | 32'(i % 8);
      wb(1'b1, 12'h500, ctlV);
      rd(12'h500, ctlV);
      r = xs();
      wb(1'b1, 12'h504, r);
      tfV = r[31:16];
      r = xs() | 32'h80000000;
      wb(1'b1, 12'h510, r);
      baseV = r[31:16] & (16'hFFFF << ctlV[27:24]);
      for (int j = 0; j < 3; j++)
      begin
        r = xs();
        a = {baseV, 16'h0} | (r & ~{16'hFFFF << ctlV[27:24], 16'h0}
          & (j == 1 ? 32'hFFFFFFFF : 32'h00000FFF)) | (j == 1 ? 32'h1000 : 32'h0);
        req(j == 2 ? r : a, r[16], r[17]);
      end
    end
    wb(1'b1, 12'h510, 32'h0);
    baseV = 16'h0; winEn = 1'b0;
    req(32'h00002000, 1'b0, 1'b1);
    wb(1'b1, 12'h500, ctlV);
    winEn = 1'b1;
    req(32'h00002000, 1'b1, 1'b0);
    ctlV[31] = 1'b0;
    wb(1'b1, 12'h500, ctlV);
    winEn = 1'b0;
    req(32'h00002000, 1'b1, 1'b0);
    finish_test;
  end
endmodule
